// file: verilog/i2cm_pkg.sv
// How it works
// - Master drives every SCL pulse, Start, Stop.
// - Transfer ends by Stop or Repeated Start.
// - Write: address, direction 0, bytes, ack in.
// - Read: address, direction 1, bytes shifted in.
// - Master returns acknowledge after each received byte: SDA low unless bit 4 is set.
// - Ninth slot of a sent byte samples slave acknowledge into status.
// - Flag set at end of ninth clock.
// - Baud generator period comes from divider input.
// - Start request bit 0; flag after start.
// - Stop request bit 2; flag when Stop done.
// - Repeated start honoured only in hold with no request pending, never in idle.
// - Repeated start: SCL low, then SDA released.
// - SDA high: release SCL, both high one period.
// - SDA low one period, clear request, hold.
// - Start seen sets bit 3; flag after timeout.
// - Collision: SDA low at rise, early SCL fall.
// - Buffer write during repeated start sets write collision.
// - Control writes blocked during repeated start.
package i2cm_pkg;

	// Bit positions inside serial_control_two.
	localparam int CTL_START = 0;
	localparam int CTL_RSTART = 1;
	localparam int CTL_STOP = 2;
	localparam int CTL_RECV = 3;
	localparam int CTL_ACKDT = 4;
	localparam int CTL_W = 5;

	// Width of the baud divider and its generator.
	localparam int BRG_W = 7;
	// Index of the acknowledge slot within a byte frame.
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [BRG_W-1:0] BRG_STEP = 7'h01;

	// One-hot engine states.
	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_START = 12'h002,
		ST_RS_LOW = 12'h004,
		ST_RS_SDAHI = 12'h008,
		ST_RS_SCLHI = 12'h010,
		ST_RS_SDALO = 12'h020,
		ST_HOLD = 12'h040,
		ST_BIT_LOW = 12'h080,
		ST_BIT_HIGH = 12'h100,
		ST_STOP_LOW = 12'h200,
		ST_STOP_HIGH = 12'h400,
		ST_STOP_END = 12'h800
	} i2cm_state_t;

endpackage : i2cm_pkg

// file: verilog/i2cm_master.sv
`timescale 1ns/10ps
module i2cm_master import i2cm_pkg::*; #(
	parameter int DATA_W = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	input wire logic [BRG_W-1:0] i_baud_div,
	input wire logic i_ctl_wr,
	input wire logic [CTL_W-1:0] i_ctl_wdata,
	input wire logic i_tx_valid,
	input wire logic [DATA_W-1:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [DATA_W-1:0] o_rx_data,
	input wire logic i_rx_ready,
	input wire logic i_irq_clr,
	input wire logic i_write_collision_flag_clr,
	input wire logic i_bcol_clr,
	input wire logic i_scl_in,
	output logic o_scl_out,
	output logic o_scl_oe,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic [CTL_W-1:0] o_ctl,
	output logic o_ack_stat,
	output logic o_start_seen,
	output logic o_stop_seen,
	output logic o_irq_flag,
	output logic o_write_collision_flag,
	output logic o_bus_collision,
	output logic o_busy
);

	localparam int PTR_W = $clog2(DEPTH);

	// The buffer pointers wrap by overflow, so depth must be a power of two.
	if (DEPTH < 2 || (1 << PTR_W) != DEPTH || DATA_W != 8) begin : g_chk
		$error("i2cm_master: DEPTH must be a power of two >= 2, DATA_W 8");
	end

	// Whole state of the block in one record.
	typedef struct packed {
		i2cm_state_t state;                    // Engine state.
		logic [CTL_W-1:0] ctl;                 // serial_control_two bits.
		logic [BRG_W-1:0] brg;                 // Baud generator count.
		logic brg_run;                         // Generator is counting.
		logic [DATA_W-1:0] sh;                 // Shift register.
		logic [3:0] bits;                      // Bit slot within a byte.
		logic rx_mode;                         // Byte is being received.
		logic scl_oe;                          // Pull SCL low.
		logic sda_oe;                          // Pull SDA low.
		logic scl_o;                           // Level driven when enabled.
		logic sda_o;                           // Level driven when enabled.
		logic scl_m;                           // SCL first sync stage.
		logic scl_s;                           // SCL second sync stage.
		logic scl_p;                           // SCL previous sample.
		logic sda_m;                           // SDA first sync stage.
		logic sda_s;                           // SDA second sync stage.
		logic sda_p;                           // SDA previous sample.
		logic irq;                             // serial_port_irq_flag.
		logic ack_stat;                        // Last acknowledge seen.
		logic start_seen;                      // Start seen on the bus.
		logic stop_seen;                       // Stop seen on the bus.
		logic write_collision_flag;                            // write_collision_flag.
		logic bcol;                            // Bus collision event.
		logic tx_ready;                        // Buffer write can be taken.
		logic busy;                            // Engine not idle.
		logic [DEPTH-1:0][DATA_W-1:0] mem;     // Receive buffer words.
		logic [PTR_W-1:0] wp;                  // Buffer write pointer.
		logic [PTR_W-1:0] rp;                  // Buffer read pointer.
		logic [PTR_W:0] cnt;                   // Words held.
		logic rx_valid;                        // Head word is valid.
		logic [DATA_W-1:0] rx_data;            // Copy of the head word.
	} i2cm_regs_t;

	i2cm_regs_t q_reg;
	i2cm_regs_t q_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;

	// Abandons a sequence: both lines released, enables dropped.
	function automatic i2cm_regs_t i2cm_abort(input i2cm_regs_t s);
		i2cm_regs_t r;
		r = s;
		r.scl_oe = 1'b0;
		r.sda_oe = 1'b0;
		r.brg_run = 1'b0;
		r.ctl[CTL_RECV:CTL_START] = '0;
		r.bcol = 1'b1;
		r.state = ST_IDLE;
		return r;
	endfunction : i2cm_abort

	// Starts one baud generator period from the divider value.
	function automatic i2cm_regs_t i2cm_load(input i2cm_regs_t s,
			input logic [BRG_W-1:0] div);
		i2cm_regs_t r;
		r = s;
		r.brg = div;
		r.brg_run = 1'b1;
		return r;
	endfunction : i2cm_load

	// Reset is asserted at once and released in step with the clock.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// Next state of the whole block.
	always_comb begin
		logic tout;
		logic scl_hi;
		logic sda_hi;
		logic evt_idle;
		logic push;
		logic pop;
		logic drive_low;
		tout = 1'b0;
		scl_hi = 1'b0;
		sda_hi = 1'b0;
		evt_idle = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		drive_low = 1'b0;
		q_next = q_reg;

		// Pins pass two flops; logic reads the second stage and, for bus events, also the third.
		q_next.scl_m = i_scl_in;
		q_next.scl_s = q_reg.scl_m;
		q_next.scl_p = q_reg.scl_s;
		q_next.sda_m = i_sda_in;
		q_next.sda_s = q_reg.sda_m;
		q_next.sda_p = q_reg.sda_s;
		scl_hi = q_reg.scl_s;
		sda_hi = q_reg.sda_s;

		// Generator counts down; a period is divider plus one cycles.
		tout = q_reg.brg_run && (q_reg.brg == '0);
		if (q_reg.brg_run && (q_reg.brg != '0)) begin
			q_next.brg = q_reg.brg - BRG_STEP;
		end

		// Bus watch: SDA falling under high SCL is a Start.
		if (scl_hi && q_reg.scl_p && q_reg.sda_p && !sda_hi) begin
			q_next.start_seen = 1'b1;
			q_next.stop_seen = 1'b0;
		end else if (scl_hi && q_reg.scl_p && !q_reg.sda_p && sda_hi) begin
			q_next.start_seen = 1'b0;
			q_next.stop_seen = 1'b1;
		end

		// Clears come first so that a set in the same cycle wins.
		if (i_irq_clr) begin
			q_next.irq = 1'b0;
		end
		if (i_write_collision_flag_clr) begin
			q_next.write_collision_flag = 1'b0;
		end
		if (i_bcol_clr) begin
			q_next.bcol = 1'b0;
		end

		// Events cannot be queued, so a new one is taken only by a quiet engine.
		evt_idle = ((q_reg.state == ST_IDLE) || (q_reg.state == ST_HOLD)) &&
			(q_reg.ctl[CTL_RECV:CTL_START] == '0);
		// The lock starts on the edge that sets the repeated start, so a
		// write in the hold cycle that follows is refused as well.
		if (i_ctl_wr && !q_reg.ctl[CTL_RSTART]) begin
			q_next.ctl[CTL_ACKDT] = i_ctl_wdata[CTL_ACKDT];
			if (evt_idle && q_reg.state == ST_IDLE) begin
				q_next.ctl[CTL_START] = i_ctl_wdata[CTL_START];
			end
			if (evt_idle && q_reg.state == ST_HOLD) begin
				q_next.ctl[CTL_RSTART] = i_ctl_wdata[CTL_RSTART];
				q_next.ctl[CTL_STOP] = i_ctl_wdata[CTL_STOP];
				q_next.ctl[CTL_RECV] = i_ctl_wdata[CTL_RECV];
			end
		end

		// A buffer write is taken only while the bus is held and quiet.
		if (i_tx_valid && !q_reg.tx_ready) begin
			q_next.write_collision_flag = 1'b1;
		end

		// Engine.
		case (q_reg.state)
			ST_IDLE: begin
				if (q_reg.ctl[CTL_START]) begin
					if (!scl_hi || !sda_hi) begin
						q_next = i2cm_abort(q_next);
					end else begin
						q_next.sda_oe = 1'b1;
						q_next = i2cm_load(q_next, i_baud_div);
						q_next.state = ST_START;
					end
				end
			end
			ST_START: begin
				if (tout) begin
					q_next.ctl[CTL_START] = 1'b0;
					q_next.brg_run = 1'b0;
					q_next.irq = 1'b1;
					q_next.state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Bus stays owned here between events.
				if (i_tx_valid && q_reg.tx_ready) begin
					q_next.sh = i_tx_data;
					q_next.bits = '0;
					q_next.rx_mode = 1'b0;
					q_next.scl_oe = 1'b1;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_BIT_LOW;
				end else if (q_reg.ctl[CTL_RSTART]) begin
					q_next.scl_oe = 1'b1;
					q_next.state = ST_RS_LOW;
				end else if (q_reg.ctl[CTL_STOP]) begin
					q_next.scl_oe = 1'b1;
					q_next.sda_oe = 1'b1;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_STOP_LOW;
				end else if (q_reg.ctl[CTL_RECV] &&
						(q_reg.cnt != DEPTH[PTR_W:0])) begin
					// A full buffer stalls the receive until it drains.
					q_next.ctl[CTL_RECV] = 1'b0;
					q_next.sh = '0;
					q_next.bits = '0;
					q_next.rx_mode = 1'b1;
					q_next.scl_oe = 1'b1;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_BIT_LOW;
				end
			end
			ST_RS_LOW: begin
				if (!scl_hi) begin
					q_next.sda_oe = 1'b0;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_RS_SDAHI;
				end
			end
			ST_RS_SDAHI: begin
				if (tout) begin
					if (sda_hi) begin
						q_next.scl_oe = 1'b0;
						q_next.brg_run = 1'b0;
						q_next.state = ST_RS_SCLHI;
					end else begin
						q_next = i2cm_abort(q_next);
					end
				end
			end
			ST_RS_SCLHI: begin
				if (!q_reg.brg_run) begin
					// Wait for SCL to rise, which a slave may delay.
					if (scl_hi && !sda_hi) begin
						q_next = i2cm_abort(q_next);
					end else if (scl_hi) begin
						q_next = i2cm_load(q_next, i_baud_div);
					end
				end else if (!scl_hi || !sda_hi) begin
					q_next = i2cm_abort(q_next);
				end else if (tout) begin
					q_next.sda_oe = 1'b1;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_RS_SDALO;
				end
			end
			ST_RS_SDALO: begin
				if (tout) begin
					// No reload: SDA stays low and SCL high until the next event.
					q_next.ctl[CTL_RSTART] = 1'b0;
					q_next.brg_run = 1'b0;
					q_next.irq = 1'b1;
					q_next.state = ST_HOLD;
				end
			end
			ST_BIT_LOW: begin
				if (q_reg.bits == ACK_SLOT) begin
					drive_low = q_reg.rx_mode && !q_reg.ctl[CTL_ACKDT];
				end else begin
					drive_low = !q_reg.rx_mode && !q_reg.sh[DATA_W-1];
				end
				q_next.sda_oe = drive_low;
				if (tout) begin
					q_next.scl_oe = 1'b0;
					q_next.brg_run = 1'b0;
					q_next.state = ST_BIT_HIGH;
				end
			end
			ST_BIT_HIGH: begin
				if (!q_reg.brg_run) begin
					if (scl_hi) begin
						q_next = i2cm_load(q_next, i_baud_div);
					end
				end else if (tout) begin
					q_next.scl_oe = 1'b1;
					if (q_reg.bits == ACK_SLOT) begin
						if (q_reg.rx_mode) begin
							push = 1'b1;
						end else begin
							q_next.ack_stat = sda_hi;
						end
						// SDA keeps its level until the next phase.
						// Letting go as SCL falls breaks the hold time.
						q_next.brg_run = 1'b0;
						q_next.irq = 1'b1;
						q_next.state = ST_HOLD;
					end else begin
						q_next.sh = {q_reg.sh[DATA_W-2:0], sda_hi};
						q_next.bits = q_reg.bits + BIT_STEP;
						q_next = i2cm_load(q_next, i_baud_div);
						q_next.state = ST_BIT_LOW;
					end
				end
			end
			ST_STOP_LOW: begin
				if (tout) begin
					q_next.scl_oe = 1'b0;
					q_next.brg_run = 1'b0;
					q_next.state = ST_STOP_HIGH;
				end
			end
			ST_STOP_HIGH: begin
				if (!q_reg.brg_run) begin
					if (scl_hi) begin
						q_next = i2cm_load(q_next, i_baud_div);
					end
				end else if (tout) begin
					q_next.sda_oe = 1'b0;
					q_next = i2cm_load(q_next, i_baud_div);
					q_next.state = ST_STOP_END;
				end
			end
			ST_STOP_END: begin
				if (tout) begin
					q_next.ctl[CTL_STOP] = 1'b0;
					q_next.brg_run = 1'b0;
					q_next.irq = 1'b1;
					q_next.state = ST_IDLE;
				end
			end
			default: begin
				q_next = i2cm_abort(q_next);
			end
		endcase

		// Receive buffer: the engine fills, the user side drains.
		pop = q_reg.rx_valid && i_rx_ready;
		if (push) begin
			q_next.mem[q_reg.wp] = q_reg.sh;
			q_next.wp = q_reg.wp + 1'b1;
		end
		if (pop) begin
			q_next.rp = q_reg.rp + 1'b1;
		end
		if (push && !pop) begin
			q_next.cnt = q_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			q_next.cnt = q_reg.cnt - 1'b1;
		end
		q_next.rx_valid = (q_next.cnt != '0);
		q_next.rx_data = q_next.mem[q_next.rp];

		q_next.tx_ready = (q_next.state == ST_HOLD) &&
			(q_next.ctl[CTL_RECV:CTL_START] == '0) &&
			!(i_tx_valid && q_reg.tx_ready);
		q_next.busy = (q_next.state != ST_IDLE);
	end

	// State register; a low clock enable freezes everything.
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= '0;
			q_reg.state <= ST_IDLE;
			// Sync stages start at the idle bus level, so that no false
			// bus event or collision follows the release of reset.
			q_reg.scl_m <= 1'b1;
			q_reg.scl_s <= 1'b1;
			q_reg.scl_p <= 1'b1;
			q_reg.sda_m <= 1'b1;
			q_reg.sda_s <= 1'b1;
			q_reg.sda_p <= 1'b1;
		end else if (i_clk_en) begin
			q_reg <= q_next;
		end
	end

	assign o_tx_ready = q_reg.tx_ready;
	assign o_rx_valid = q_reg.rx_valid;
	assign o_rx_data = q_reg.rx_data;
	assign o_scl_out = q_reg.scl_o;
	assign o_scl_oe = q_reg.scl_oe;
	assign o_sda_out = q_reg.sda_o;
	assign o_sda_oe = q_reg.sda_oe;
	assign o_ctl = q_reg.ctl;
	assign o_ack_stat = q_reg.ack_stat;
	assign o_start_seen = q_reg.start_seen;
	assign o_stop_seen = q_reg.stop_seen;
	assign o_irq_flag = q_reg.irq;
	assign o_write_collision_flag = q_reg.write_collision_flag;
	assign o_bus_collision = q_reg.bcol;
	assign o_busy = q_reg.busy;

endmodule : i2cm_master

// file: bench/i2cm_slave_model.sv
`timescale 1ns/10ps
// Target device model; it acts only on bus edges.
module i2cm_slave_model (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_ack_en,
	input wire logic [7:0] i_rd_byte,
	output logic o_sda_oe
);
	int cnt = -1; // Slot in the frame; -1 before the first fall.
	logic [7:0] sh = 8'h00; // Bits taken from the engine.
	logic [7:0] rb = 8'h00; // Byte being returned.
	logic rd = 1'b0; // High while returning data.
	logic first = 1'b0; // High during the address byte.
	logic oe = 1'b0; // Pulls data low while high.
	logic scl_q = 1'b1; // Clock level at the last event.
	assign o_sda_oe = oe;
	// One process owns all state, so no variable has two writers.
	always @(i_scl or i_sda) begin
		if (i_scl && scl_q) begin
			// Data moved under a high clock: start or stop restarts.
			cnt = -1;
			first = !i_sda;
			rd = 1'b0;
			oe = 1'b0;
		end else if (i_scl) begin
			// Bits are taken on the rise; a refused byte ends the read.
			if (cnt < 8) sh = {sh[6:0], i_sda};
			else if (i_sda) rd = 1'b0;
		end else if (scl_q) begin
			// The line only changes while the clock is low.
			cnt = (cnt >= 8) ? 0 : cnt + 1;
			if (cnt == 8) begin
				if (first) rd = sh[0];
				rb = first ? i_rd_byte : ~rb;
				oe = (first || !rd) && i_ack_en;
				first = 1'b0;
			end else begin
				oe = rd && !rb[7-cnt];
			end
		end
		scl_q = i_scl;
	end
endmodule : i2cm_slave_model

// file: bench/i2cm_master_asserts.sv
`timescale 1ns/10ps
module i2cm_master_asserts import i2cm_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	input wire logic i_ctl_wr,
	input wire logic [CTL_W-1:0] i_ctl_wdata,
	input wire logic i_tx_valid,
	input wire logic o_scl_oe,
	input wire logic o_sda_oe,
	input wire logic [CTL_W-1:0] o_ctl,
	input wire logic o_start_seen,
	input wire logic o_irq_flag,
	input wire logic o_write_collision_flag,
	input wire logic o_bus_collision,
	input wire logic o_busy
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	logic wr; // A control write that the engine sees.
	assign wr = i_ctl_wr && i_clk_en;
	// Data pulled low inside a repeated start.
	sequence rs_sda_low;
		o_ctl[CTL_RSTART] && $rose(o_sda_oe);
	endsequence
	// Repeated start finished without a collision.
	sequence rs_done;
		$fell(o_ctl[CTL_RSTART]) && !o_bus_collision;
	endsequence
	AST_START_IRQ: assert property (
		$fell(o_ctl[CTL_START]) && !o_bus_collision |-> o_irq_flag && o_start_seen)
		else $error("Start ended without its flags.");
	AST_RS_IDLE: assert property (
		wr && !o_busy && !i_ctl_wdata[CTL_START] && i_ctl_wdata[CTL_RSTART]
		|=> !o_ctl[CTL_RSTART]) else $error("Repeated start taken in idle.");
	AST_RS_SCL: assert property (
		$rose(o_ctl[CTL_RSTART]) |-> ##[0:1] o_scl_oe)
		else $error("Repeated start did not pull the clock.");
	AST_RS_SDA: assert property (
		rs_sda_low |-> !o_scl_oe ##1 (o_sda_oe && !o_scl_oe))
		else $error("Data low phase too short.");
	AST_RS_END: assert property (
		rs_done |-> o_irq_flag && o_sda_oe && !o_scl_oe)
		else $error("Repeated start ended in a wrong state.");
	AST_RS_BLOCK: assert property (
		o_ctl[CTL_RSTART] && wr |=> !o_ctl[CTL_START] && !o_ctl[CTL_STOP]
		&& !o_ctl[CTL_RECV] && $stable(o_ctl[CTL_ACKDT]))
		else $error("Control write taken during repeated start.");
	AST_WRITE_COLLISION_FLAG: assert property (
		o_ctl[CTL_RSTART] && i_tx_valid |=> o_write_collision_flag)
		else $error("Buffer write did not collide.");
	AST_STOP: assert property (
		$fell(o_ctl[CTL_STOP]) && !o_bus_collision
		|-> o_irq_flag && !o_scl_oe && !o_sda_oe) else $error("Bad stop end.");
	AST_BCOL: assert property (
		$rose(o_bus_collision) |-> ##[0:1] (!o_scl_oe && !o_sda_oe && !o_busy))
		else $error("Collision did not free the bus.");
endmodule : i2cm_master_asserts
bind i2cm_master i2cm_master_asserts i_chk (.i_sys_clk, .i_rst_b, .i_clk_en,
	.i_ctl_wr, .i_ctl_wdata, .i_tx_valid, .o_scl_oe, .o_sda_oe, .o_ctl,
	.o_start_seen, .o_irq_flag, .o_write_collision_flag, .o_bus_collision,
	.o_busy);

// file: bench/i2c_master_repeated_start_bench.sv
`timescale 1ns/10ps
module i2c_master_repeated_start_bench;
	import i2cm_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_clk_en = 1'b1; // Freezes the engine while low.
	logic [BRG_W-1:0] i_baud_div = 7'h03;
	logic i_ctl_wr = 1'b0;
	logic [CTL_W-1:0] i_ctl_wdata = 5'h00;
	logic i_tx_valid = 1'b0;
	logic [7:0] i_tx_data = 8'h00;
	logic i_rx_ready = 1'b0;
	logic i_irq_clr = 1'b0;
	logic i_write_collision_flag_clr = 1'b0;
	logic i_bcol_clr = 1'b0;
	logic ack_en = 1'b1; // Target acknowledges while high.
	logic tb_scl_low = 1'b0; // Rival party pulling the clock.
	logic tb_sda_low = 1'b0; // Rival party pulling data.
	logic [7:0] rd_byte = 8'h00; // First byte the target returns.
	logic s_oe;
	logic o_tx_ready, o_rx_valid, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
	logic [7:0] o_rx_data;
	logic [CTL_W-1:0] o_ctl;
	logic o_ack_stat, o_start_seen, o_stop_seen, o_irq_flag;
	logic o_write_collision_flag, o_bus_collision, o_busy;
	// Pull-ups on both lines; any party pulling low wins.
	wire i_scl_in = !(o_scl_oe || tb_scl_low);
	wire i_sda_in = !(o_sda_oe || s_oe || tb_sda_low);
	int n_fail = 0;
	int checked = 0;
	int unsigned seed = 3;
	int run = 0; // Cycles the engine has held the clock low.
	int lo_q[$]; // Finished clock-low lengths.
	int rx_q[$]; // Model of the receive buffer.
	logic [8:0] wbits = 9'h000; // Last nine bits seen on the wire.
	logic [7:0] a;
	logic [6:0] snap; // Bus enables and control seen while frozen.
	int k, d;
	always #20 i_sys_clk = !i_sys_clk;
	i2cm_master i_dut (.i_sys_clk, .i_rst_b, .i_clk_en, .i_baud_div, .i_ctl_wr,
		.i_ctl_wdata, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid,
		.o_rx_data, .i_rx_ready, .i_irq_clr, .i_write_collision_flag_clr, .i_bcol_clr,
		.i_scl_in, .o_scl_out, .o_scl_oe, .i_sda_in, .o_sda_out, .o_sda_oe,
		.o_ctl, .o_ack_stat, .o_start_seen, .o_stop_seen, .o_irq_flag,
		.o_write_collision_flag, .o_bus_collision, .o_busy);
	i2cm_slave_model i_tgt (.i_scl(i_scl_in), .i_sda(i_sda_in),
		.i_ack_en(ack_en), .i_rd_byte(rd_byte), .o_sda_oe(s_oe));
	// Wire bits are taken where the bus samples them.
	always @(posedge i_scl_in) wbits <= {wbits[7:0], i_sda_in};
	// Low phases are measured where outputs have settled.
	always @(negedge i_sys_clk) begin
		if (o_scl_oe === 1'b1) run++;
		else if (run > 0) begin
			lo_q.push_back(run);
			run = 0;
		end
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : tick
	// Waits a bounded time for the event flag, then clears it.
	task automatic wait_irq();
		int i;
		for (i = 0; i < 3000 && o_irq_flag !== 1'b1; i++) tick(1);
		chk(o_irq_flag, 1'b1);
		i_irq_clr = 1'b1;
		tick(1);
		i_irq_clr = 1'b0;
	endtask : wait_irq
	task automatic ctl(input logic [CTL_W-1:0] v);
		i_ctl_wdata = v;
		i_ctl_wr = 1'b1;
		tick(1);
		i_ctl_wr = 0;
	endtask : ctl
	// Sends one byte at a random rate and checks it on the wire.
	task automatic send(input logic [7:0] b);
		int i;
		i_baud_div = 7'(1 + rnd() % 15);
		for (i = 0; i < 3000 && o_tx_ready !== 1'b1; i++) tick(1);
		i_tx_data = b;
		i_tx_valid = 1'b1;
		lo_q.delete();
		tick(1);
		i_tx_valid = 1'b0;
		wait_irq();
		chk(wbits[8:1], b);
		chk(o_ack_stat, !ack_en);
		chk(o_scl_oe, 1'b1);
		for (i = 1; i < lo_q.size(); i++) chk(lo_q[i], i_baud_div + 1);
	endtask : send
	task automatic end_of_test();
		if (n_fail == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	// A hang is cut short well after the sequence should end.
	initial begin
		#(40 * 60000);
		n_fail++;
		end_of_test();
	end
	initial begin
		tick(10);
		chk({o_scl_oe, o_sda_oe, o_busy, o_irq_flag}, 8'h00);
		tick(10);
		i_rst_b = 1'b1;
		tick(4);
		ctl(5'h01);
		wait_irq();
		chk({o_ctl, o_start_seen}, 8'h01);
		a = rnd() & 8'hFE;
		send(a);
		ack_en = 1'b0;
		send(rnd());
		ack_en = 1'b1;
		// Buffer and control writes inside a repeated start are lost.
		ctl(5'h02);
		i_tx_valid = 1'b1;
		tick(1);
		i_tx_valid = 1'b0;
		ctl(5'h04);
		wait_irq();
		chk({o_ctl, o_write_collision_flag, o_start_seen, o_sda_oe}, 8'h07);
		chk(o_tx_ready, 1'b1);
		chk({o_scl_out, o_sda_out}, 8'h00);
		i_write_collision_flag_clr = 1'b1;
		tick(1);
		i_write_collision_flag_clr = 1'b0;
		rd_byte = rnd();
		send(a | 8'h01);
		// Two receives fill the buffer while the consumer stalls.
		for (k = 0; k < 2; k++) begin
			rx_q.push_back(k ? ~rd_byte : rd_byte);
			ctl({k[0], 4'h8});
			wait_irq();
			chk(wbits[8:1], rx_q[k]);
			chk(wbits[0], k[0]);
		end
		while (rx_q.size() > 0) begin
			tick(3);
			chk(o_rx_data, rx_q.pop_front());
			i_rx_ready = 1'b1;
			tick(1);
			i_rx_ready = 1'b0;
		end
		chk(o_rx_valid, 1'b0);
		ctl(5'h04);
		// A low clock enable must hold the stop where it stands.
		tick(2);
		i_clk_en = 1'b0;
		snap = {o_scl_oe, o_sda_oe, o_ctl};
		tick(40);
		chk({o_scl_oe, o_sda_oe, o_ctl}, snap);
		i_clk_en = 1'b1;
		wait_irq();
		chk({o_stop_seen, o_scl_oe, o_sda_oe, o_busy}, 8'h08);
		ctl(5'h02);
		chk(o_ctl, 5'h00);
		// A rival on the clock, then on data, during the high phase.
		i_baud_div = 7'h0A;
		for (k = 0; k < 2; k++) begin
			ctl(5'h01);
			wait_irq();
			ctl(5'h02);
			for (d = 0; d < 500 && o_scl_oe !== 1'b1; d++) tick(1);
			for (d = 0; d < 500 && o_scl_oe !== 1'b0; d++) tick(1);
			tick(5);
			tb_scl_low = !k;
			tb_sda_low = k;
			for (d = 0; d < 500 && o_bus_collision !== 1'b1; d++) tick(1);
			chk({o_bus_collision, o_scl_oe, o_sda_oe, o_busy, o_ctl[3:0]}, 8'h80);
			tb_scl_low = 1'b0;
			tb_sda_low = 1'b0;
			i_bcol_clr = 1'b1;
			i_irq_clr = 1'b1;
			tick(1);
			i_bcol_clr = 1'b0;
			i_irq_clr = 1'b0;
			tick(4);
			chk(o_bus_collision, 1'b0);
		end
		end_of_test();
	end
endmodule : i2c_master_repeated_start_bench
